// ===== verilog/ifsu_regs.vh
// register map, field positions and reset values of the upper flag status block
`ifndef IFSU_REGS_VH
`define IFSU_REGS_VH

`define IFSU_ADDR_W        16
`define IFSU_SEL0_OFF      16'h3008
`define IFSU_SEL1_OFF      16'h300C
`define IFSU_FLAG0_OFF     16'h3010
`define IFSU_FLAG1_OFF     16'h3014
`define IFSU_EVST_OFF      16'h3020
`define IFSU_EVLVL_OFF     16'h3024
`define IFSU_IGNCNT_OFF    16'h3028

`define IFSU_SEL_RST       32'h00002000
`define IFSU_FLAG_RST      32'h00000000
`define IFSU_FLAG_MASK     32'hAF83A000

`define IFSU_COLL_BIT      31
`define IFSU_OUTL_BIT      29
`define IFSU_UFLOW_BIT     27
`define IFSU_OFLOW_BIT     26
`define IFSU_THRESH_BIT    25
`define IFSU_EMPTY_BIT     24
`define IFSU_FULL_BIT      23
`define IFSU_TOERR_BIT     17
`define IFSU_TODONE_BIT    16
`define IFSU_EOS_BIT       15
`define IFSU_BOOT_BIT      13

`define IFSU_IGN_W         16
`define IFSU_IGN_MAX       16'hFFFF

`define IFSU_RESP_OKAY     2'h0
`define IFSU_RESP_SLVERR   2'h2

`endif

// ===== verilog/ifsu_sticky.v
// sticky event bits, hardware set wins over write-one-to-clear
`timescale 1ns/100ps
`default_nettype none
`include "ifsu_regs.vh"

module ifsu_sticky
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [31:0] set_vec,
   input  wire [31:0] clr_vec,
   output wire [31:0] q
);

   reg [31:0] q_reg;
   wire [31:0] q_next;

   assign q_next = ((q_reg & ~clr_vec) | set_vec) & `IFSU_FLAG_MASK;
   assign q = q_reg;

   always @(posedge aclk)
   begin
      if (!aresetn)
         q_reg <= `IFSU_FLAG_RST;
      else
         q_reg <= q_next;
   end

endmodule // ifsu_sticky

`default_nettype wire

// ===== verilog/ifsu_axil_slave.v
// axi4-lite slave front end: captures writes and answers reads
`timescale 1ns/100ps
`default_nettype none
`include "ifsu_regs.vh"

module ifsu_axil_slave
(
   input  wire                    aclk,
   input  wire                    aresetn,
   input  wire [`IFSU_ADDR_W-1:0] s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output wire                    s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output wire                    s_axi_wready,
   output wire [1:0]              s_axi_bresp,
   output wire                    s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [`IFSU_ADDR_W-1:0] s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output wire                    s_axi_arready,
   output wire [31:0]             s_axi_rdata,
   output wire [1:0]              s_axi_rresp,
   output wire                    s_axi_rvalid,
   input  wire                    s_axi_rready,
   output wire                    wr_en,
   output wire [`IFSU_ADDR_W-1:0] wr_addr,
   output wire [31:0]             wr_data,
   output wire [3:0]              wr_strb,
   input  wire                    wr_err,
   output wire [`IFSU_ADDR_W-1:0] rd_addr,
   input  wire [31:0]             rd_data,
   input  wire                    rd_err
);

   reg                    aw_held_reg;
   reg [`IFSU_ADDR_W-1:0] awaddr_reg;
   reg                    w_held_reg;
   reg [31:0]             wdata_reg;
   reg [3:0]              wstrb_reg;
   reg                    bvalid_reg;
   reg [1:0]              bresp_reg;
   reg                    rvalid_reg;
   reg [31:0]             rdata_reg;
   reg [1:0]              rresp_reg;

   assign s_axi_awready = ~aw_held_reg;
   assign s_axi_wready  = ~w_held_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   // write fires once address and data are both held and no response waits
   assign wr_en   = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_addr = awaddr_reg;
   assign wr_data = wdata_reg;
   assign wr_strb = wstrb_reg;
   assign rd_addr = s_axi_araddr;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= {`IFSU_ADDR_W{1'b0}};
         w_held_reg  <= 1'b0;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `IFSU_RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= `IFSU_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && !aw_held_reg)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         else if (wr_en)
            aw_held_reg <= 1'b0;
         if (s_axi_wvalid && !w_held_reg)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         else if (wr_en)
            w_held_reg <= 1'b0;
         if (wr_en)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_err ? `IFSU_RESP_SLVERR : `IFSU_RESP_OKAY;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
         if (s_axi_arvalid && !rvalid_reg)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_data;
            rresp_reg  <= rd_err ? `IFSU_RESP_SLVERR : `IFSU_RESP_OKAY;
         end
         else if (s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end

endmodule // ifsu_axil_slave

`default_nettype wire

// ===== verilog/ifsu_top.v
// upper interrupt flag status block: event capture, select registers, flag readback
//
// Overview of operation
// - two 32-bit flag status registers sit at 0x3010 and 0x3014, share one layout and reset to zero.
// - every flag bit is read-only, 1 means asserted, and writes to the flag registers change nothing.
// - bit 31 sets when a second-sequence request arrives while the first runs, and that request is dropped.
// - bits 27 to 23 report fifo underflow, overflow, threshold, empty and full; bit 29 reports outliers.
// - bit 17 reports a sequencer timeout error, bit 16 timeout count finished, bit 15 end of sequence.
// - bit 13 sets when the bootload has completed.
// - each flag has an enable at the same position in its select register; bootload enable resets to 1.
`timescale 1ns/100ps
`default_nettype none
`include "ifsu_regs.vh"

module ifsu_top
(
   input  wire                    aclk,
   input  wire                    aresetn,
   input  wire [`IFSU_ADDR_W-1:0] s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output wire                    s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output wire                    s_axi_wready,
   output wire [1:0]              s_axi_bresp,
   output wire                    s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [`IFSU_ADDR_W-1:0] s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output wire                    s_axi_arready,
   output wire [31:0]             s_axi_rdata,
   output wire [1:0]              s_axi_rresp,
   output wire                    s_axi_rvalid,
   input  wire                    s_axi_rready,
   input  wire                    seq_a_busy,
   input  wire                    seq_b_request,
   output wire                    seq_b_start,
   input  wire                    outlier_evt,
   input  wire                    fifo_underflow_evt,
   input  wire                    fifo_overflow_evt,
   input  wire                    fifo_threshold_evt,
   input  wire                    fifo_empty_evt,
   input  wire                    fifo_full_evt,
   input  wire                    seq_timeout_error_evt,
   input  wire                    seq_timeout_finished_evt,
   input  wire                    end_of_sequence_evt,
   input  wire                    bootload_done_evt,
   output wire                    irq
);

   wire                    wr_en;
   wire [`IFSU_ADDR_W-1:0] wr_addr;
   wire [31:0]             wr_data;
   wire [3:0]              wr_strb;
   wire [`IFSU_ADDR_W-1:0] rd_addr;
   reg  [31:0]             rd_data;
   reg                     rd_err;
   reg                     wr_err;

   reg  [31:0]             sel0_reg;
   reg  [31:0]             sel0_next;
   reg  [31:0]             sel1_reg;
   reg  [31:0]             sel1_next;
   reg  [31:0]             evlvl_reg;
   reg  [`IFSU_IGN_W-1:0]  igncnt_reg;
   reg  [`IFSU_IGN_W-1:0]  igncnt_next;
   reg                     irq_reg;

   reg  [31:0]             evt_vec;
   reg  [31:0]             evst_clr;
   wire [31:0]             evst;
   wire [31:0]             flag_status_0;
   wire [31:0]             flag_status_1;
   wire                    collision;

   // byte-lane merge of a write into an old value
   function [31:0] strb_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  strb;
      integer      i;
      begin
         strb_merge = old_val;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (strb[i])
               strb_merge[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
   endfunction

   // full-address match, so misaligned accesses fall out as unmapped
   function addr_hit;
      input [`IFSU_ADDR_W-1:0] addr;
      input [`IFSU_ADDR_W-1:0] off;
      begin
         addr_hit = (addr == off);
      end
   endfunction

   // register address decode shared by reads and writes
   function addr_mapped;
      input [`IFSU_ADDR_W-1:0] addr;
      begin
         addr_mapped = addr_hit(addr, `IFSU_SEL0_OFF) | addr_hit(addr, `IFSU_SEL1_OFF) |
                       addr_hit(addr, `IFSU_FLAG0_OFF) | addr_hit(addr, `IFSU_FLAG1_OFF) |
                       addr_hit(addr, `IFSU_EVST_OFF) | addr_hit(addr, `IFSU_EVLVL_OFF) |
                       addr_hit(addr, `IFSU_IGNCNT_OFF);
      end
   endfunction

   // one write strobe aimed at one register
   function wr_hit;
      input                    en;
      input [`IFSU_ADDR_W-1:0] addr;
      input [`IFSU_ADDR_W-1:0] off;
      begin
         wr_hit = en & addr_hit(addr, off);
      end
   endfunction

   // shared status seen through one select register
   function [31:0] flag_view;
      input [31:0] status;
      input [31:0] sel;
      begin
         flag_view = status & sel & `IFSU_FLAG_MASK;
      end
   endfunction

   // counter step that sticks at its top value
   function [`IFSU_IGN_W-1:0] sat_inc;
      input [`IFSU_IGN_W-1:0] cnt;
      begin
         if (cnt == `IFSU_IGN_MAX)
            sat_inc = cnt;
         else
            sat_inc = cnt + 16'h0001;
      end
   endfunction

   ifsu_axil_slave u_slave
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_err        (wr_err),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_err        (rd_err)
   );

   assign collision   = seq_b_request & seq_a_busy;
   assign seq_b_start = seq_b_request & ~seq_a_busy;

   // event sources into their flag positions
   always @*
   begin
      evt_vec = 32'h00000000;
      evt_vec[`IFSU_COLL_BIT]   = collision;
      evt_vec[`IFSU_OUTL_BIT]   = outlier_evt;
      evt_vec[`IFSU_UFLOW_BIT]  = fifo_underflow_evt;
      evt_vec[`IFSU_OFLOW_BIT]  = fifo_overflow_evt;
      evt_vec[`IFSU_THRESH_BIT] = fifo_threshold_evt;
      evt_vec[`IFSU_EMPTY_BIT]  = fifo_empty_evt;
      evt_vec[`IFSU_FULL_BIT]   = fifo_full_evt;
      evt_vec[`IFSU_TOERR_BIT]  = seq_timeout_error_evt;
      evt_vec[`IFSU_TODONE_BIT] = seq_timeout_finished_evt;
      evt_vec[`IFSU_EOS_BIT]    = end_of_sequence_evt;
      evt_vec[`IFSU_BOOT_BIT]   = bootload_done_evt;
   end

   // write-one-to-clear of the event status, lane by lane
   always @*
   begin
      evst_clr = 32'h00000000;
      if (wr_hit(wr_en, wr_addr, `IFSU_EVST_OFF))
         evst_clr = strb_merge(32'h00000000, wr_data, wr_strb);
   end

   ifsu_sticky u_evst
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_vec (evt_vec & `IFSU_FLAG_MASK),
      .clr_vec (evst_clr),
      .q       (evst)
   );

   assign flag_status_0 = flag_view(evst, sel0_reg);
   assign flag_status_1 = flag_view(evst, sel1_reg);

   always @*
   begin
      sel0_next = sel0_reg;
      sel1_next = sel1_reg;
      if (wr_hit(wr_en, wr_addr, `IFSU_SEL0_OFF))
         sel0_next = strb_merge(sel0_reg, wr_data, wr_strb) & `IFSU_FLAG_MASK;
      if (wr_hit(wr_en, wr_addr, `IFSU_SEL1_OFF))
         sel1_next = strb_merge(sel1_reg, wr_data, wr_strb) & `IFSU_FLAG_MASK;
   end

   // saturating count of dropped second requests, cleared by any write to its own register
   always @*
   begin
      igncnt_next = igncnt_reg;
      if (wr_hit(wr_en, wr_addr, `IFSU_IGNCNT_OFF))
         igncnt_next = {`IFSU_IGN_W{1'b0}};
      else if (collision)
         igncnt_next = sat_inc(igncnt_reg);
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sel0_reg   <= `IFSU_SEL_RST;
         sel1_reg   <= `IFSU_SEL_RST;
         evlvl_reg  <= 32'h00000000;
         igncnt_reg <= {`IFSU_IGN_W{1'b0}};
         irq_reg    <= 1'b0;
      end
      else
      begin
         sel0_reg   <= sel0_next;
         sel1_reg   <= sel1_next;
         evlvl_reg  <= evt_vec & `IFSU_FLAG_MASK;
         igncnt_reg <= igncnt_next;
         irq_reg    <= |(flag_status_0 | flag_status_1);
      end
   end

   assign irq = irq_reg;

   // flag registers accept writes without effect
   always @*
   begin
      wr_err = ~addr_mapped(wr_addr);
   end

   // read mux
   always @*
   begin
      rd_err  = ~addr_mapped(rd_addr);
      rd_data = 32'h00000000;
      case (rd_addr)
         `IFSU_SEL0_OFF:
            rd_data = sel0_reg;
         `IFSU_SEL1_OFF:
            rd_data = sel1_reg;
         `IFSU_FLAG0_OFF:
            rd_data = flag_status_0;
         `IFSU_FLAG1_OFF:
            rd_data = flag_status_1;
         `IFSU_EVST_OFF:
            rd_data = evst;
         `IFSU_EVLVL_OFF:
            rd_data = evlvl_reg;
         `IFSU_IGNCNT_OFF:
            rd_data = {{(32-`IFSU_IGN_W){1'b0}}, igncnt_reg};
         default:
            rd_data = 32'h00000000;
      endcase
   end

endmodule // ifsu_top

`default_nettype wire

// ===== verification/ifsu_top_assertions.sv
// assertion checker for the upper flag status block
`timescale 1ns/100ps
`default_nettype none
module ifsu_chk
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        seq_a_busy,
   input wire logic        seq_b_request,
   input wire logic        seq_b_start,
   input wire logic        bootload_done_evt,
   input wire logic        irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_coll_refused: assert property (seq_a_busy && seq_b_request |-> !seq_b_start)
      else $error("second request passed while first runs");
   a_start_passed: assert property (!seq_a_busy && seq_b_request |-> seq_b_start)
      else $error("request not passed while idle");
   a_boot_irq: assert property (bootload_done_evt |=> ##1 irq)
      else $error("boot event did not raise irq");
   a_reset_quiet: assert property ($rose(aresetn) |-> !irq ##1 !irq)
      else $error("irq high after reset");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready high while read pending");
   a_wr_answer: assert property (s_wr_both |=> ##1 s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
endmodule // ifsu_chk

bind ifsu_top ifsu_chk i_chk
(
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .seq_a_busy(seq_a_busy), .seq_b_request(seq_b_request),
   .seq_b_start(seq_b_start), .bootload_done_evt(bootload_done_evt), .irq(irq)
);
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the upper flag status block
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [15:0] s_axi_awaddr = 16'h0;
   logic [15:0] s_axi_araddr = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        seq_a_busy = 1'h0, seq_b_request = 1'h0;
   logic [9:0]  ev = 10'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        seq_b_start, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd_v;
   int          num_errors = 0;
   int          checks = 0;
   logic [31:0] row_exp [10] = '{32'h20000000, 32'h08000000, 32'h04000000, 32'h02000000,
      32'h01000000, 32'h00800000, 32'h00020000, 32'h00010000, 32'h00008000, 32'h00002000};

   always #2 aclk = ~aclk;

   ifsu_top i_dut
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .seq_a_busy(seq_a_busy), .seq_b_request(seq_b_request), .seq_b_start(seq_b_start),
      .outlier_evt(ev[9]), .fifo_underflow_evt(ev[8]), .fifo_overflow_evt(ev[7]),
      .fifo_threshold_evt(ev[6]), .fifo_empty_evt(ev[5]), .fifo_full_evt(ev[4]),
      .seq_timeout_error_evt(ev[3]), .seq_timeout_finished_evt(ev[2]),
      .end_of_sequence_evt(ev[1]), .bootload_done_evt(ev[0]), .irq(irq)
   );

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      bit b_ok = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!b_ok)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid)
         begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'h0;
            b_ok = 1;
         end
      end
   endtask

   task automatic rd(input logic [15:0] a);
      bit r_ok = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!r_ok)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid)
         begin
            rd_v = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'h0;
            r_ok = 1;
         end
      end
   endtask

   task automatic rc(input string nm, input logic [15:0] a, input logic [31:0] e);
      rd(a);
      chk(nm, rd_v, e);
   endtask

   task automatic pulse(input logic [9:0] e);
      @(posedge aclk);
      ev <= e;
      @(posedge aclk);
      ev <= 10'h0;
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      give_verdict();
   end

   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      wr(16'h3008, 32'hFFFFFFFF);
      rc("sel0", 16'h3008, 32'hAF83A000);
      for (int i = 0; i < 10; i++)
      begin
         pulse(10'h200 >> i);
         rc("flag0 row", 16'h3010, row_exp[i]);
         rc("flag1 row", 16'h3014, row_exp[i] & 32'h00002000);
         chk("irq row", {31'h0, irq}, 32'h1);
         wr(16'h3020, row_exp[i]);
         rc("flag0 cleared", 16'h3010, 32'h0);
         chk("irq cleared", {31'h0, irq}, 32'h0);
      end
      $display("row tests done");
      pulse(10'h3FF);
      rc("all flags", 16'h3010, 32'h2F83A000);
      wr(16'h3010, 32'hFFFFFFFF);
      chk("flag0 write resp", {30'h0, resp}, 32'h0);
      rc("flag0 kept", 16'h3010, 32'h2F83A000);
      wr(16'h3014, 32'h0);
      rc("flag1 kept", 16'h3014, 32'h00002000);
      wr(16'h3020, 32'hFFFFFFFF);
      $display("read-only test done");
      wr(16'h3008, 32'h0);
      wr(16'h300C, 32'h0);
      pulse(10'h200);
      repeat (3) @(posedge aclk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rc("flag0 masked", 16'h3010, 32'h0);
      wr(16'h300C, 32'h20000000);
      rc("flag1 enabled", 16'h3014, 32'h20000000);
      chk("irq enabled", {31'h0, irq}, 32'h1);
      wr(16'h3020, 32'h20000000);
      $display("mask test done");
      @(posedge aclk);
      seq_a_busy <= 1'h1;
      seq_b_request <= 1'h1;
      #1 chk("start blocked", {31'h0, seq_b_start}, 32'h0);
      @(posedge aclk);
      seq_a_busy <= 1'h0;
      #1 chk("start passed", {31'h0, seq_b_start}, 32'h1);
      @(posedge aclk);
      seq_b_request <= 1'h0;
      rc("collision status", 16'h3020, 32'h80000000);
      rc("dropped count", 16'h3028, 32'h1);
      wr(16'h3028, 32'h0);
      rc("count cleared", 16'h3028, 32'h0);
      ev <= 10'h002;
      rc("event level", 16'h3024, 32'h00008000);
      ev <= 10'h000;
      $display("collision test done");
      rc("unmapped read", 16'h3030, 32'h0);
      chk("unmapped rresp", {30'h0, resp}, 32'h2);
      wr(16'h3030, 32'hFFFFFFFF);
      chk("unmapped bresp", {30'h0, resp}, 32'h2);
      $display("unmapped test done");
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      rc("flag0 reset", 16'h3010, 32'h0);
      rc("flag1 reset", 16'h3014, 32'h0);
      rc("status reset", 16'h3020, 32'h0);
      rc("sel0 reset", 16'h3008, 32'h00002000);
      rc("sel1 reset", 16'h300C, 32'h00002000);
      $display("reset test done");
      give_verdict();
   end
endmodule // tb
`default_nettype wire
